// ---- verilog/rfc_pkg.sv ----
package rfc_pkg;

    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam int REG_N = 16;
    localparam int IDX_GENERAL_CONFIG = 0;
    localparam int IDX_FREQ_CORRECTION_CONFIG = 1;
    localparam int IDX_TRANSMIT_CONFIG = 2;
    localparam int IDX_TRANSMIT_BYTE = 3;
    localparam int IDX_CENTER_FREQUENCY = 4;
    localparam int IDX_RECEIVE_CONFIG = 5;
    localparam int IDX_BASEBAND_FILTER_CONFIG = 6;
    localparam int IDX_RECEIVE_QUEUE_READ = 7;
    localparam int IDX_QUEUE_AND_RESET_MODE = 8;
    localparam int IDX_SYNC_PATTERN = 9;
    localparam int IDX_BIT_RATE_SETTING = 10;
    localparam int IDX_POWER_MANAGEMENT = 11;
    localparam int IDX_WAKE_TIMER_SETTING = 12;
    localparam int IDX_DUTY_CYCLE_SETTING = 13;
    localparam int IDX_BATTERY_AND_CLOCK_OUT = 14;
    localparam int IDX_PLL_CONFIG = 15;

    // ----------------------------------------
    // Command code patterns, masks, reset values
    // ----------------------------------------
    localparam logic [15:0] CMD_CODE [REG_N] = '{
        16'h8000, 16'hC400, 16'h9800, 16'hB800, 16'hA000, 16'h9000, 16'hC200, 16'hB000,
        16'hCA00, 16'hCE00, 16'hC600, 16'h8200, 16'hE000, 16'hC800, 16'hC000, 16'hCC00};
    localparam logic [15:0] CMD_MASK [REG_N] = '{
        16'hFF00, 16'hFF00, 16'hFE00, 16'hFF00, 16'hF000, 16'hF800, 16'hFF00, 16'hFF00,
        16'hFF00, 16'hFF00, 16'hFF00, 16'hFF00, 16'hE000, 16'hFF00, 16'hFF00, 16'hFF00};
    localparam logic [15:0] REG_RESET [REG_N] = '{
        16'h8008, 16'hC4F7, 16'h9800, 16'hB8AA, 16'hA680, 16'h9080, 16'hC22C, 16'hB000,
        16'hCA80, 16'hCED4, 16'hC623, 16'h8208, 16'hE196, 16'hC80E, 16'hC000, 16'hCC77};
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] SW_RESET_CMD = 16'hFE00;
    localparam logic [7:0] PLL_CMD_CODE = 8'hCC;
    localparam logic [15:0] PLL_FORCE_ONE = 16'h0010;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int PLL_EDGE_LSB = 5;
    localparam int PLL_FORCED_BIT = 4;
    localparam int PLL_PD_DELAY_BIT = 3;
    localparam int PLL_DITHER_OFF_BIT = 2;
    localparam int PLL_WIDE_BW_BIT = 0;
    localparam int GLITCH_MODE_BIT = 0;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] FRAME_OVER = 5'h11;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int RESET_TIME_NS = 250000;
    localparam int SW_RESET_CYCLES = RESET_TIME_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef logic [REG_N-1:0][15:0] rfc_cfg_t;

    typedef struct packed {
        logic [1:0] clockBufferEdgeTime;
        logic phaseDetectorDelayOn;
        logic pllDitherOff;
        logic pllWideBandwidth;
    } rfc_pll_t;

    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_RESET = 1'b1
    } rfc_mode_t;

    typedef struct packed {
        logic sckS1;
        logic sckS2;
        logic sckS3;
        logic csnS1;
        logic csnS2;
        logic csnS3;
        logic sdiS1;
        logic sdiS2;
        logic rstnS1;
        logic rstnS2;
        logic glS1;
        logic glS2;
        rfc_mode_t mode;
        logic [15:0] rstCnt;
        logic frameOk;
        logic [4:0] bitCnt;
        logic [15:0] rxShift;
        logic [15:0] txShift;
        logic sdo;
        logic sdoOe;
        logic [15:0] status;
        rfc_cfg_t cfg;
    } rfc_state_t;

endpackage

// ---- verilog/rfc_command_regs.sv ----
// Behaviour
// - PLL write selected by code 11001100b
// - PLL register resets to 0xCC77
// - Bits 6-5 set clock buffer edge time
// - PLL bit 4 always reads one
// - PLL bit 3 enables phase detector delay
// - PLL bit 2 set disables dithering
// - PLL bit 0 selects wide loop bandwidth
// - Each register has own code, reset value
// - Power-on reset restores every register
// - Commands ignored while any reset runs
// - Sensitive mode default; bit 0 selects normal
// - Every reset reselects sensitive mode
// - 0xFE00 resets only in sensitive mode
// - Software reset restores all, lasts 0.25 ms
// - Reset pin low restores power-on values
module rfc_command_regs #(
    parameter int unsigned RESET_CYCLES = rfc_pkg::SW_RESET_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic spiSck,
    input wire logic spiCs_n,
    input wire logic spiSdi,
    output logic spiSdo,
    output logic spiSdoOe,
    input wire logic resetPin_n,
    input wire logic supplyGlitch,
    input wire logic [15:0] statusFlags,
    output rfc_pkg::rfc_cfg_t cfgRegs,
    output rfc_pkg::rfc_pll_t pllCfg,
    output logic normalResetMode,
    output logic resetBusy
);

    rfc_pkg::rfc_state_t q;
    rfc_pkg::rfc_state_t d;
    rfc_pkg::rfc_cfg_t resetCfg;
    logic sckRise;
    logic sckFall;
    logic csnFall;
    logic csnRise;
    logic cmdValid;
    logic [15:0] cmdWord;
    logic cmdHit;
    logic swReset;
    logic hardReset;

    // ----------------------------------------
    // Reset image of the register bank
    // ----------------------------------------
    always_comb
    begin
        for (int i = 0; i < rfc_pkg::REG_N; i++)
        begin
            resetCfg[i] = rfc_pkg::REG_RESET[i];
        end
    end

    // ----------------------------------------
    // Edge and frame detection
    // ----------------------------------------
    assign sckRise = q.sckS2 & ~q.sckS3;
    assign sckFall = ~q.sckS2 & q.sckS3;
    assign csnFall = ~q.csnS2 & q.csnS3;
    assign csnRise = q.csnS2 & ~q.csnS3;
    assign cmdWord = q.rxShift;
    assign cmdValid = csnRise & q.frameOk & (q.bitCnt == rfc_pkg::FRAME_BITS) & (q.mode == rfc_pkg::ST_RUN);
    assign swReset = cmdValid & (cmdWord == rfc_pkg::SW_RESET_CMD)
        & ~q.cfg[rfc_pkg::IDX_QUEUE_AND_RESET_MODE][rfc_pkg::GLITCH_MODE_BIT];
    // Glitch is a held level: reset lasts while it stays high
    // pin reset; glitch only in sensitive mode
    assign hardReset = ~q.rstnS2
        | (q.glS2 & ~q.cfg[rfc_pkg::IDX_QUEUE_AND_RESET_MODE][rfc_pkg::GLITCH_MODE_BIT]);

    always_comb
    begin
        cmdHit = 1'b0;
        for (int i = 0; i < rfc_pkg::REG_N; i++)
        begin
            if ((cmdWord & rfc_pkg::CMD_MASK[i]) == rfc_pkg::CMD_CODE[i])
            begin
                cmdHit = 1'b1;
            end
        end
        // Soft reset word outranks the wake timer pattern
        if (cmdWord == rfc_pkg::SW_RESET_CMD)
        begin
            cmdHit = 1'b0;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        d = q;
        d.sckS1 = spiSck;
        d.sckS2 = q.sckS1;
        d.sckS3 = q.sckS2;
        d.csnS1 = spiCs_n;
        d.csnS2 = q.csnS1;
        d.csnS3 = q.csnS2;
        d.sdiS1 = spiSdi;
        d.sdiS2 = q.sdiS1;
        d.rstnS1 = resetPin_n;
        d.rstnS2 = q.rstnS1;
        d.glS1 = supplyGlitch;
        d.glS2 = q.glS1;
        d.status = statusFlags;
        d.sdoOe = ~q.csnS2;

        // Status word shifts out on every frame; the host samples it on every frame
        if (csnFall)
        begin
            d.txShift = q.status;
            d.sdo = q.status[15];
        end
        else if (sckFall && !q.csnS2)
        begin
            d.txShift = {q.txShift[14:0], 1'b0};
            d.sdo = q.txShift[14];
        end

        if (hardReset)
        begin
            // registers and mode back to defaults
            d.cfg = resetCfg;
            d.mode = rfc_pkg::ST_RESET;
            d.rstCnt = RESET_CYCLES[15:0];
            d.frameOk = 1'b0;
        end
        else
        begin
            case (q.mode)
                rfc_pkg::ST_RESET:
                begin
                    d.frameOk = 1'b0;
                    if (q.rstCnt <= 16'h0001)
                    begin
                        d.mode = rfc_pkg::ST_RUN;
                        d.rstCnt = 16'h0000;
                    end
                    else
                    begin
                        d.rstCnt = q.rstCnt - 16'h0001;
                    end
                end
                rfc_pkg::ST_RUN:
                begin
                    if (csnFall)
                    begin
                        d.frameOk = 1'b1;
                        d.bitCnt = 5'h00;
                    end
                    else if (sckRise && !q.csnS2 && q.frameOk)
                    begin
                        d.rxShift = {q.rxShift[14:0], q.sdiS2};
                        // Saturates so an overlong frame never wraps to sixteen
                        if (q.bitCnt != rfc_pkg::FRAME_OVER)
                        begin
                            d.bitCnt = q.bitCnt + 5'h01;
                        end
                    end
                    if (csnRise)
                    begin
                        d.frameOk = 1'b0;
                    end
                    if (swReset)
                    begin
                        // restore and time the short interval
                        d.cfg = resetCfg;
                        d.mode = rfc_pkg::ST_RESET;
                        d.rstCnt = RESET_CYCLES[15:0];
                    end
                    else if (cmdValid && cmdHit)
                    begin
                        for (int i = 0; i < rfc_pkg::REG_N; i++)
                        begin
                            if ((cmdWord & rfc_pkg::CMD_MASK[i]) == rfc_pkg::CMD_CODE[i])
                            begin
                                d.cfg[i] = cmdWord;
                            end
                        end
                        d.cfg[rfc_pkg::IDX_PLL_CONFIG] = d.cfg[rfc_pkg::IDX_PLL_CONFIG] | rfc_pkg::PLL_FORCE_ONE;
                    end
                end
                default:
                begin
                    d.mode = rfc_pkg::ST_RESET;
                    d.rstCnt = RESET_CYCLES[15:0];
                end
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            q <= '0;
            // Sync stages preset to idle levels, no false edge
            q.csnS1 <= 1'b1;
            q.csnS2 <= 1'b1;
            q.csnS3 <= 1'b1;
            q.rstnS1 <= 1'b1;
            q.rstnS2 <= 1'b1;
            q.status <= rfc_pkg::STATUS_RESET;
            q.cfg <= resetCfg;
            q.mode <= rfc_pkg::ST_RUN;
        end
        else
        begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign cfgRegs = q.cfg;
    assign pllCfg.clockBufferEdgeTime = q.cfg[rfc_pkg::IDX_PLL_CONFIG][rfc_pkg::PLL_EDGE_LSB +: 2];
    assign pllCfg.phaseDetectorDelayOn = q.cfg[rfc_pkg::IDX_PLL_CONFIG][rfc_pkg::PLL_PD_DELAY_BIT];
    assign pllCfg.pllDitherOff = q.cfg[rfc_pkg::IDX_PLL_CONFIG][rfc_pkg::PLL_DITHER_OFF_BIT];
    assign pllCfg.pllWideBandwidth = q.cfg[rfc_pkg::IDX_PLL_CONFIG][rfc_pkg::PLL_WIDE_BW_BIT];
    assign normalResetMode = q.cfg[rfc_pkg::IDX_QUEUE_AND_RESET_MODE][rfc_pkg::GLITCH_MODE_BIT];
    assign resetBusy = (q.mode == rfc_pkg::ST_RESET);
    assign spiSdo = q.sdo;
    assign spiSdoOe = q.sdoOe;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    pll_por_value_a: assert property ($fell(srst) |-> q.cfg[rfc_pkg::IDX_PLL_CONFIG] == 16'hCC77)
        else $error("PLL register wrong after power-on");
    pll_bit_four_a: assert property (q.cfg[rfc_pkg::IDX_PLL_CONFIG][rfc_pkg::PLL_FORCED_BIT])
        else $error("PLL bit 4 not one");
    pll_write_a: assert property (cmdValid && !hardReset && cmdWord[15:8] == 8'hCC |=>
        q.cfg[rfc_pkg::IDX_PLL_CONFIG] == ($past(cmdWord) | 16'h0010) && pllCfg.pllWideBandwidth == $past(cmdWord[0]))
        else $error("PLL write not applied");
    reset_holds_a: assert property (resetBusy |-> q.cfg == resetCfg && !normalResetMode)
        else $error("Registers changed during reset");
    sw_reset_a: assert property (cmdValid && cmdWord == 16'hFE00 && !normalResetMode |=>
        resetBusy && q.rstCnt == RESET_CYCLES[15:0])
        else $error("Software reset not started");
    sw_reset_normal_a: assert property (cmdValid && cmdWord == 16'hFE00 && normalResetMode && !hardReset |=>
        !resetBusy && $stable(q.cfg))
        else $error("Software reset acted in normal mode");
    unmatched_a: assert property (cmdValid && !cmdHit && !swReset && !hardReset |=> $stable(q.cfg))
        else $error("Unmatched command changed registers");
    frame_only_a: assert property (cmdValid |-> $past(q.csnS2) == 1'b0 && q.bitCnt == 5'h10)
        else $error("Command taken without full frame");
    pin_reset_a: assert property (!q.rstnS2 |=> resetBusy && q.cfg == resetCfg)
        else $error("Pin reset not applied");
    ignore_busy_a: assert property (resetBusy |-> !cmdValid)
        else $error("Command taken during reset");
    por_image_a: assert property ($fell(srst) |-> q.cfg == resetCfg && !resetBusy)
        else $error("Registers not at power-on values");
    mode_default_a: assert property ($fell(srst) |-> !normalResetMode)
        else $error("Sensitive mode not default after power-on");
    glitch_ignored_a: assert property (q.glS2 && normalResetMode && q.rstnS2 |=> !resetBusy)
        else $error("Glitch reset acted in normal mode");
    busy_count_a: assert property (resetBusy && !hardReset && q.rstCnt > 16'h0001 |=>
        resetBusy && q.rstCnt == $past(q.rstCnt) - 16'h0001)
        else $error("Reset interval count skipped");
    busy_end_a: assert property (resetBusy && !hardReset && q.rstCnt <= 16'h0001 |=> !resetBusy)
        else $error("Reset interval did not end");

    pll_write_c: cover property (cmdValid && cmdWord[15:8] == rfc_pkg::PLL_CMD_CODE);
    sw_reset_c: cover property (swReset ##1 resetBusy);
    mode_switch_c: cover property ($rose(normalResetMode));
    short_frame_c: cover property (csnRise && q.frameOk && q.bitCnt != rfc_pkg::FRAME_BITS);
    glitch_reset_c: cover property ($rose(resetBusy) && q.glS2);

endmodule // rfc_command_regs

// ---- tb/rfc_host_model.sv ----
module rfc_host_model (
    input wire logic clk,
    output logic spiSck,
    output logic spiCs_n,
    output logic spiSdi,
    input wire logic spiSdo
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        spiSck = 1'b0;
        spiCs_n = 1'b1;
        spiSdi = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ----------------------------------------
    // Frame driver
    // ----------------------------------------
    // framed MSB-first words
    task automatic send(input logic [15:0] w, input int n, output logic [15:0] rd);
        rd = '0;
        spiCs_n = 1'b0;
        gap(2);
        for (int i = 15; i > 15 - n; i--)
        begin
            spiSdi = w[i];
            gap(4);
            rd = {rd[14:0], spiSdo};
            spiSck = 1'b1;
            gap(4);
            spiSck = 1'b0;
        end
        gap(4);
        spiCs_n = 1'b1;
        // Released line must not show a stale bit
        spiSdi = ~spiSdi;
        gap(8);
    endtask
endmodule // rfc_host_model

// ---- tb/rfc_command_regs_test.sv ----
module rfc_command_regs_test;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        rfc_pkg::rfc_cfg_t cfg;
        logic [15:0] sts;
        logic busy;
    } rfc_note_t;

    logic clk;
    logic srst;
    logic spiSck;
    logic spiCs_n;
    logic spiSdi;
    logic spiSdo;
    logic spiSdoOe;
    logic resetPin_n;
    logic supplyGlitch;
    logic [15:0] statusFlags;
    rfc_pkg::rfc_cfg_t cfgRegs;
    rfc_pkg::rfc_pll_t pllCfg;
    logic normalResetMode;
    logic resetBusy;
    rfc_pkg::rfc_cfg_t expCfg;
    logic [15:0] expSts;
    logic [15:0] rdSeen;
    logic expBusy;
    rfc_note_t notes[$];
    event chk;
    int errCount = 0;
    int totalChecks = 0;
    localparam int RST_CYCLES = 40;
    int busyRun = 0;
    int busyLen = 0;

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Length of the last busy interval, in edges seen high
    always @(posedge clk)
    begin
        if (resetBusy === 1'b1)
            busyRun <= busyRun + 1;
        else
        begin
            if (busyRun != 0)
                busyLen <= busyRun;
            busyRun <= 0;
        end
    end

    rfc_command_regs #(.RESET_CYCLES(RST_CYCLES)) i_dut (.clk(clk), .srst(srst), .spiSck(spiSck), .spiCs_n(spiCs_n),
        .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe), .resetPin_n(resetPin_n),
        .supplyGlitch(supplyGlitch), .statusFlags(statusFlags), .cfgRegs(cfgRegs), .pllCfg(pllCfg),
        .normalResetMode(normalResetMode), .resetBusy(resetBusy));

    rfc_host_model i_host (.clk(clk), .spiSck(spiSck), .spiCs_n(spiCs_n), .spiSdi(spiSdi), .spiSdo(spiSdo));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic endOfTest();
        $display("checks=%0d mismatches=%0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic note();
        notes.push_back('{expCfg, expSts, expBusy});
        ->chk;
    endtask

    task automatic resetExp();
        for (int i = 0; i < rfc_pkg::REG_N; i++)
            expCfg[i] = rfc_pkg::REG_RESET[i];
        expBusy = 1'b0;
    endtask

    task automatic cmd(input logic [15:0] w, input int n);
        statusFlags = 16'($urandom);
        tick(4);
        expSts = statusFlags;
        i_host.send(w, n, rdSeen);
    endtask

    task automatic wr(input logic [15:0] w);
        logic hit;
        hit = 1'b0;
        cmd(w, 16);
        for (int i = 0; i < rfc_pkg::REG_N; i++)
            if (!hit && w != rfc_pkg::SW_RESET_CMD && (w & rfc_pkg::CMD_MASK[i]) == rfc_pkg::CMD_CODE[i])
            begin
                expCfg[i] = (i == rfc_pkg::IDX_PLL_CONFIG) ? (w | rfc_pkg::PLL_FORCE_ONE) : w;
                hit = 1'b1;
            end
        note();
    endtask

    task automatic waitIdle();
        int n;
        n = 0;
        tick(4);
        while (resetBusy !== 1'b0 && n < 2000)
        begin
            tick(1);
            n++;
        end
        check(n < 2000, 1);
    endtask

    // ----------------------------------------
    // Result monitor
    // ----------------------------------------
    initial
    begin
        rfc_note_t n;
        forever
        begin
            @(chk);
            n = notes.pop_front();
            check(cfgRegs, n.cfg);
            check(rdSeen, n.sts);
            check(resetBusy, n.busy);
            check(normalResetMode, n.cfg[8][0]);
            check(pllCfg, {n.cfg[15][6:5], n.cfg[15][3:2], n.cfg[15][0]});
        end
    end

    initial
    begin
        #200000;
        errCount++;
        endOfTest();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [15:0] w;
        void'($urandom(58099));
        srst = 1'b1;
        resetPin_n = 1'b1;
        supplyGlitch = 1'b0;
        statusFlags = 16'h0000;
        tick(16);
        srst = 1'b0;
        resetExp();
        tick(4);
        wr(16'h0000);
        $display("test power-on values done");
        for (int i = 0; i < rfc_pkg::REG_N; i++)
        begin
            w = rfc_pkg::CMD_CODE[i] | (16'($urandom) & ~rfc_pkg::CMD_MASK[i]);
            if (i == rfc_pkg::IDX_QUEUE_AND_RESET_MODE)
                w[0] = 1'b0;
            if (i == rfc_pkg::IDX_PLL_CONFIG)
            begin
                w[7] = 1'b0;
                w[1] = 1'b1;
            end
            if (w == rfc_pkg::SW_RESET_CMD)
                w[0] = 1'b1;
            wr(w);
        end
        for (int k = 0; k < 8; k++)
        begin
            w = {rfc_pkg::PLL_CMD_CODE, 8'($urandom)};
            w[6:5] = 2'(k);
            w[7] = 1'b0;
            w[1] = 1'b1;
            wr(w);
        end
        $display("test register writes done");
        cmd(16'hCCF3, 15);
        wr(16'h7E5A);
        $display("test refused frames done");
        cmd(rfc_pkg::SW_RESET_CMD, 16);
        resetExp();
        expBusy = 1'b1;
        note();
        cmd(16'h8155, 16);
        waitIdle();
        check(busyLen, RST_CYCLES);
        expBusy = 1'b0;
        wr(16'h0000);
        $display("test software reset done");
        wr(16'hCA81);
        wr(rfc_pkg::SW_RESET_CMD);
        supplyGlitch = 1'b1;
        tick(10);
        supplyGlitch = 1'b0;
        wr(16'h0000);
        $display("test normal mode done");
        resetPin_n = 1'b0;
        tick(10);
        resetPin_n = 1'b1;
        waitIdle();
        resetExp();
        wr(16'h0000);
        wr(16'h8123);
        supplyGlitch = 1'b1;
        tick(10);
        supplyGlitch = 1'b0;
        waitIdle();
        resetExp();
        wr(16'h0000);
        $display("test pin and glitch reset done");
        wr(16'hC0E5);
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        resetExp();
        tick(4);
        wr(16'h0000);
        $display("test second power-on done");
        endOfTest();
    end
endmodule // rfc_command_regs_test
